// ### rtl/nvc_defs.vh
// Constants for the nonvolatile data memory access controller
//
// Notes on behaviour
// [R1] Eight-bit read/write data holding register, zero at reset, carries the byte.
// [R2] Control register keeps only bits 3..0; bits 7..4 read zero.
// [R3] Control bit 3 is write arm, reset zero; clear arm blocks writes.
// [R4] Setting control bit 2 starts a write; hardware clears it at completion.
// [R5] Write go is ignored unless write arm was already set.
// [R6] Control bit 1 is read arm, reset zero; clear arm blocks reads.
// [R7] Setting control bit 0 starts a read; hardware clears it when done.
// [R8] Read go is ignored unless read arm was already set.
// [R9] Software never sets all four control bits in one write.
// [R10] Software ensures the sub clock is stable before a write.
// [R11] Software leaves the control register alone until a write completes.
// [R12] Read end loads the addressed byte into data; kept until next operation.
// [R13] Software loads address and data, then arm and go in consecutive cycles.
// [R14] Software masks global interrupts around arming and starting a write.
// [R15] Write cycle is timed by a timer asynchronous to the system clock.
// [R16] Reset clears write arm so no write happens until re-armed.
// [R17] Write end sets the nonvolatile flag and the group flag.
// [R18] Vector request needs all three enables set and a stack not full.
// [R19] Servicing clears group flag and global enable; nonvolatile flag stays.
// [R20] Software avoids low-power modes while a cycle is in progress.
// [R21] Software rewrites the address for every read; no auto-increment.
// [R22] Pointer high byte resets to zero, so the control register is hidden.
// [R23] Seven-bit address register, reset zero, bit 7 reads zero.
// [R24] Control register sits at location 40H of sector 1, indirect only.
// [R25] A read completes a fixed few system cycles after read go.
// [R26] Write completion is synchronised before clearing go and setting flags.
`ifndef NVC_DEFS_VH
`define NVC_DEFS_VH

// Direct register locations on the core register port
`define NVC_ADDR_PTR_LO   8'h00
`define NVC_ADDR_PTR_HI   8'h01
`define NVC_ADDR_IND      8'h02
`define NVC_ADDR_NVADDR   8'h03
`define NVC_ADDR_NVDATA   8'h04
`define NVC_ADDR_IRQ      8'h05

// Indirect location of the transfer control register
`define NVC_CTRL_SECTOR   8'h01
`define NVC_CTRL_LOC      8'h40

// Transfer control fields
`define NVC_BIT_RGO       0
`define NVC_BIT_RARM      1
`define NVC_BIT_WGO       2
`define NVC_BIT_WARM      3

// Interrupt register fields
`define NVC_BIT_NV_EN     0
`define NVC_BIT_NV_FLAG   1
`define NVC_BIT_GRP_EN    2
`define NVC_BIT_GRP_FLAG  3
`define NVC_BIT_GIE       4

// Reset values
`define NVC_RST_BYTE      8'h00
`define NVC_RST_ADDR      7'h00

// Timing counts
`define NVC_RD_CYCLES     3'h4
`define NVC_WR_SUB_TICKS  4'h8

`endif

// ### rtl/nvc_data_eeprom_ctrl.v
// Nonvolatile data memory access controller behind the core register port
`include "nvc_defs.vh"

module nvc_data_eeprom_ctrl (
   ref_clk,
   sys_rst,
   sfr_addr,
   sfr_wr,
   sfr_rd,
   sfr_wdata,
   sfr_rdata,
   sub_clock,
   vector_ack,
   stack_full,
   vector_req,
   nv_busy
);
   input  wire       ref_clk;
   input  wire       sys_rst;
   input  wire [7:0] sfr_addr;
   input  wire       sfr_wr;
   input  wire       sfr_rd;
   input  wire [7:0] sfr_wdata;
   output wire [7:0] sfr_rdata;
   input  wire       sub_clock;
   input  wire       vector_ack;
   input  wire       stack_full;
   output wire       vector_req;
   output wire       nv_busy;

   // One-hot cycle states
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_READ  = 3'b010;
   localparam [2:0] ST_WRITE = 3'b100;

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   reg  [7:0] mem [0:127];
   reg  [2:0] st_r;
   reg  [2:0] st_nxt;
   reg  [7:0] ptr_lo_r;
   reg  [7:0] ptr_hi_r;
   reg  [6:0] nv_address_reg_r;
   reg  [7:0] nv_data_holding_r;
   reg        write_arm_r;
   reg        write_go_r;
   reg        read_arm_r;
   reg        read_go_r;
   reg  [6:0] wr_addr_r;
   reg  [7:0] wr_data_r;
   reg  [2:0] rd_cnt_r;
   reg  [3:0] sub_cnt_r;
   reg        sub_s1_r;
   reg        sub_s2_r;
   reg        sub_s3_r;
   reg        wr_done_r;
   reg        nv_irq_enable_r;
   reg        nv_irq_flag_r;
   reg        grp_irq_enable_r;
   reg        grp_irq_flag_r;
   reg        global_irq_enable_r;
   reg  [7:0] rdata_r;
   reg  [7:0] rdata_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire       ctrl_sel;
   wire       ctrl_wr;
   wire       irq_wr;
   wire       idle;
   wire       wgo_req;
   wire       rgo_req;
   wire       rd_end;
   wire       sub_tick;
   wire       wr_timer_end;
   wire [7:0] ctrl_view;
   wire [7:0] irq_view;

   // Control register reachable only via indirect port at sector 1, 40H
   assign ctrl_sel = (ptr_hi_r == `NVC_CTRL_SECTOR) &&
                     (ptr_lo_r == `NVC_CTRL_LOC);             // see [R24] [R22]
   assign ctrl_wr  = sfr_wr && (sfr_addr == `NVC_ADDR_IND) && ctrl_sel;
   assign irq_wr   = sfr_wr && (sfr_addr == `NVC_ADDR_IRQ);
   assign idle     = st_r[0];

   // Go accepted only with arm already set before this write
   assign wgo_req  = ctrl_wr && sfr_wdata[`NVC_BIT_WGO] &&
                     write_arm_r && idle;                     // see [R5] [R3]
   assign rgo_req  = ctrl_wr && sfr_wdata[`NVC_BIT_RGO] &&
                     read_arm_r && idle && !wgo_req;          // see [R8] [R6]

   assign rd_end       = st_r[1] && (rd_cnt_r == 3'h0);
   assign sub_tick     = sub_s2_r && !sub_s3_r;
   assign wr_timer_end = st_r[2] && sub_tick &&
                         (sub_cnt_r == (`NVC_WR_SUB_TICKS - 4'h1));

   // Upper four control bits have no storage
   assign ctrl_view = {4'h0, write_arm_r, write_go_r,
                       read_arm_r, read_go_r};               // see [R2]
   assign irq_view  = {3'h0, global_irq_enable_r, grp_irq_flag_r,
                       grp_irq_enable_r, nv_irq_flag_r, nv_irq_enable_r};

   ////////////////////////////////////////////////////////////////////////////
   // Cycle state machine
   // Next state
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (wgo_req) begin
               st_nxt = ST_WRITE;
            end else if (rgo_req) begin
               st_nxt = ST_READ;
            end
         end
         ST_READ: begin
            if (rd_end) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (wr_done_r) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // State register
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sub clock timer
   // Two-stage synchroniser, third stage for edge detect
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sub_s1_r <= 1'b0;
         sub_s2_r <= 1'b0;
         sub_s3_r <= 1'b0;
      end else begin
         sub_s1_r <= sub_clock;
         sub_s2_r <= sub_s1_r;
         sub_s3_r <= sub_s2_r;
      end
   end

   // Write length counted in sub clock edges
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sub_cnt_r <= 4'h0;
         wr_done_r <= 1'b0;
      end else begin
         wr_done_r <= wr_timer_end;                           // see [R26]
         if (!st_r[2]) begin
            sub_cnt_r <= 4'h0;
         end else if (sub_tick) begin
            sub_cnt_r <= sub_cnt_r + 4'h1;                    // see [R15]
         end
      end
   end

   // Read length in system cycles
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_cnt_r <= 3'h0;
      end else if (rgo_req) begin
         rd_cnt_r <= `NVC_RD_CYCLES - 3'h1;                   // see [R25]
      end else if (st_r[1] && rd_cnt_r != 3'h0) begin
         rd_cnt_r <= rd_cnt_r - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory array (nonvolatile, no reset)
   // Commit latched byte on the registered write-done pulse, one cycle after the write timer ends
   always @(posedge ref_clk) begin
      if (wr_done_r) begin
         mem[wr_addr_r] <= wr_data_r;
      end
   end

   // Latch address and data at write start
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_addr_r <= `NVC_RST_ADDR;
         wr_data_r <= `NVC_RST_BYTE;
      end else if (wgo_req) begin
         wr_addr_r <= nv_address_reg_r;
         wr_data_r <= nv_data_holding_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Direct registers
   // Pointer bytes, address and data
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ptr_lo_r          <= `NVC_RST_BYTE;
         ptr_hi_r          <= `NVC_RST_BYTE;                  // see [R22]
         nv_address_reg_r  <= `NVC_RST_ADDR;                  // see [R23]
         nv_data_holding_r <= `NVC_RST_BYTE;                  // see [R1]
      end else begin
         if (sfr_wr && sfr_addr == `NVC_ADDR_PTR_LO) begin
            ptr_lo_r <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == `NVC_ADDR_PTR_HI) begin
            ptr_hi_r <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == `NVC_ADDR_NVADDR) begin
            nv_address_reg_r <= sfr_wdata[6:0];               // see [R23]
         end
         if (rd_end) begin
            nv_data_holding_r <= mem[nv_address_reg_r];       // see [R12]
         end else if (sfr_wr && sfr_addr == `NVC_ADDR_NVDATA) begin
            nv_data_holding_r <= sfr_wdata;                   // see [R1]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer control register
   // Arm bits are plain storage; go bits set by accepted request only
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         write_arm_r <= 1'b0;                                 // see [R16] [R3]
         read_arm_r  <= 1'b0;                                 // see [R6]
         write_go_r  <= 1'b0;
         read_go_r   <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            write_arm_r <= sfr_wdata[`NVC_BIT_WARM];
            read_arm_r  <= sfr_wdata[`NVC_BIT_RARM];
         end
         if (wgo_req) begin
            write_go_r <= 1'b1;                               // see [R4]
         end else if (wr_done_r) begin
            write_go_r <= 1'b0;                               // see [R4] [R26]
         end
         if (rgo_req) begin
            read_go_r <= 1'b1;                                // see [R7]
         end else if (rd_end) begin
            read_go_r <= 1'b0;                                // see [R7]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt flags and enables
   // Hardware set wins over software clear
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nv_irq_enable_r     <= 1'b0;
         nv_irq_flag_r       <= 1'b0;
         grp_irq_enable_r    <= 1'b0;
         grp_irq_flag_r      <= 1'b0;
         global_irq_enable_r <= 1'b0;
      end else begin
         if (irq_wr) begin
            nv_irq_enable_r  <= sfr_wdata[`NVC_BIT_NV_EN];
            grp_irq_enable_r <= sfr_wdata[`NVC_BIT_GRP_EN];
         end
         if (wr_done_r) begin
            nv_irq_flag_r <= 1'b1;                            // see [R17]
         end else if (irq_wr) begin
            nv_irq_flag_r <= sfr_wdata[`NVC_BIT_NV_FLAG];     // see [R19]
         end
         if (wr_done_r) begin
            grp_irq_flag_r <= 1'b1;                           // see [R17]
         end else if (vector_ack) begin
            grp_irq_flag_r <= 1'b0;                           // see [R19]
         end else if (irq_wr) begin
            grp_irq_flag_r <= sfr_wdata[`NVC_BIT_GRP_FLAG];
         end
         if (vector_ack) begin
            global_irq_enable_r <= 1'b0;                      // see [R19]
         end else if (irq_wr) begin
            global_irq_enable_r <= sfr_wdata[`NVC_BIT_GIE];
         end
      end
   end

   // Vector request gated by all enables and stack room
   assign vector_req = nv_irq_enable_r && grp_irq_enable_r &&
                       global_irq_enable_r && nv_irq_flag_r &&
                       grp_irq_flag_r && !stack_full;         // see [R18]

   assign nv_busy = !idle;

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   // Read mux; unmapped and hidden locations return zero
   always @* begin
      rdata_nxt = 8'h00;
      case (sfr_addr)
         `NVC_ADDR_PTR_LO: begin
            rdata_nxt = ptr_lo_r;
         end
         `NVC_ADDR_PTR_HI: begin
            rdata_nxt = ptr_hi_r;
         end
         `NVC_ADDR_IND: begin
            rdata_nxt = ctrl_sel ? ctrl_view : 8'h00;         // see [R24]
         end
         `NVC_ADDR_NVADDR: begin
            rdata_nxt = {1'b0, nv_address_reg_r};             // see [R23]
         end
         `NVC_ADDR_NVDATA: begin
            rdata_nxt = nv_data_holding_r;
         end
         `NVC_ADDR_IRQ: begin
            rdata_nxt = irq_view;
         end
         default: begin
            rdata_nxt = 8'h00;
         end
      endcase
   end

   // Registered read data, held between reads
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else if (sfr_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign sfr_rdata = rdata_r;

endmodule

// ### bench/nvc_checker.sv
// Port-level assertions for the nonvolatile access controller
`include "nvc_defs.vh"
module nvc_checker (
   input logic       ref_clk,
   input logic       sys_rst,
   input logic [7:0] sfr_addr,
   input logic       sfr_wr,
   input logic       sfr_rd,
   input logic [7:0] sfr_wdata,
   input logic [7:0] sfr_rdata,
   input logic       sub_clock,
   input logic       vector_ack,
   input logic       stack_full,
   input logic       vector_req,
   input logic       nv_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Read port and register field checks
   property p_rdata_hold;
      !sfr_rd |=> $stable(sfr_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without read");
   property p_ctrl_high_zero;
      sfr_rd && sfr_addr == `NVC_ADDR_IND |=> sfr_rdata[7:4] == 4'h0;
   endproperty
   a_ctrl_high_zero: assert property (p_ctrl_high_zero)
      else $error("control upper bits set");
   property p_addr_top_zero;
      sfr_rd && sfr_addr == `NVC_ADDR_NVADDR |=> !sfr_rdata[7];
   endproperty
   a_addr_top_zero: assert property (p_addr_top_zero)
      else $error("address bit 7 set");
   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt request checks
   property p_stack_block;
      vector_req |-> !stack_full;
   endproperty
   a_stack_block: assert property (p_stack_block)
      else $error("request with full stack");
   property p_ack_drop;
      vector_ack |=> !vector_req;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("request kept after service");
   ////////////////////////////////////////////////////////////////////////////////
   // Busy cycle origin and length
   property p_busy_cause;
      $rose(nv_busy) |-> $past(sfr_wr) && $past(sfr_addr) == `NVC_ADDR_IND;
   endproperty
   a_busy_cause: assert property (p_busy_cause)
      else $error("busy without control write");
   property p_busy_ends;
      $rose(nv_busy) |-> ##[1:300] !nv_busy;
   endproperty
   a_busy_ends: assert property (p_busy_ends)
      else $error("cycle never finished");
   property p_read_len;
      $rose(nv_busy) && !$past(sfr_wdata[2]) |-> nv_busy [*4] ##1 !nv_busy;
   endproperty
   a_read_len: assert property (p_read_len)
      else $error("read length wrong");
   c_read: cover property ($rose(nv_busy) && !$past(sfr_wdata[2]));
   c_write: cover property ($rose(nv_busy) && $past(sfr_wdata[2]));
   c_req: cover property (vector_req ##1 vector_ack);
endmodule
bind nvc_data_eeprom_ctrl nvc_checker chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sub_clock(sub_clock),
   .vector_ack(vector_ack), .stack_full(stack_full), .vector_req(vector_req),
   .nv_busy(nv_busy)
);

// ### bench/nvc_core_model.sv
// Behavioural core driving the register port and the sub clock
module nvc_core_model (
   input  logic       ref_clk,
   output logic [7:0] sfr_addr,
   output logic       sfr_wr,
   output logic       sfr_rd,
   output logic [7:0] sfr_wdata,
   input  logic [7:0] sfr_rdata,
   output logic       sub_clock,
   output logic       vector_ack,
   output logic       stack_full
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle bus at time zero
   initial begin
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      sub_clock = 1'b0;
      vector_ack = 1'b0;
      stack_full = 1'b0;
   end
   // Stable free-running sub clock; even-ns toggles never meet a rising system edge
   always #32 sub_clock = ~sub_clock;
   // One write cycle, strobe left up for a following write
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      sfr_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Release the bus, lines show inverted junk
   task idle;
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      sfr_addr <= ~sfr_addr;
      sfr_wdata <= ~sfr_wdata;
      @(posedge ref_clk);
   endtask
   // Read strobe, then take the settled data one edge later
   task rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      sfr_wr <= 1'b0;
      @(posedge ref_clk);
      idle;
      d = sfr_rdata;
   endtask
   // Interrupt service pulse
   task ack;
      vector_ack <= 1'b1;
      @(posedge ref_clk);
      vector_ack <= 1'b0;
      @(posedge ref_clk);
   endtask
endmodule

// ### bench/tb.sv
// Self-checking bench for the nonvolatile access controller
`include "nvc_defs.vh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       ref_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
   logic       sfr_wr, sfr_rd, sub_clock, vector_ack, stack_full, vector_req, nv_busy;
   int         n_errors = 0;
   int         total_checks = 0;
   // Rows: address, written byte, expected readback
   logic [23:0] rows [9] = '{24'h03ff7f, 24'h04a5a5, 24'h004040, 24'h010101, 24'h02f202,
                             24'h020000, 24'h06ff00, 24'h051f1f, 24'h050000};
   always #5 ref_clk = ~ref_clk;
   nvc_data_eeprom_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .sub_clock(sub_clock), .vector_ack(vector_ack), .stack_full(stack_full),
      .vector_req(vector_req), .nv_busy(nv_busy));
   nvc_core_model core (.ref_clk(ref_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sub_clock(sub_clock),
      .vector_ack(vector_ack), .stack_full(stack_full));
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task close_out;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Poll a control bit until hardware clears it, bounded
   task poll(input int b);
      int i;
      logic [7:0] c;
      for (i = 0; i < 200; i++) begin
         core.rd(`NVC_ADDR_IND, c);
         if (!c[b]) break;
      end
      `CHK("go bit clear", 1'b0, c[b])
      if (c[b] !== 1'b0) close_out;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      // Register table walk
      foreach (rows[i]) begin
         core.wr(rows[i][23:16], rows[i][15:8]);
         core.idle;
         core.rd(rows[i][23:16], v);
         `CHK("reg row", rows[i][7:0], v)
      end
      // Mid-run reset clears registers and hides control
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      core.rd(`NVC_ADDR_NVDATA, v);
      `CHK("data reset", 8'h00, v)
      core.rd(`NVC_ADDR_NVADDR, v);
      `CHK("addr reset", 8'h00, v)
      core.wr(`NVC_ADDR_PTR_LO, `NVC_CTRL_LOC);
      core.wr(`NVC_ADDR_IND, 8'h08);
      core.wr(`NVC_ADDR_PTR_HI, `NVC_CTRL_SECTOR);
      core.idle;
      core.rd(`NVC_ADDR_IND, v);
      `CHK("ctrl hidden", 8'h00, v)
      // Go bits without arm are ignored
      core.wr(`NVC_ADDR_IND, 8'h04);
      core.idle;
      core.rd(`NVC_ADDR_IND, v);
      `CHK("wgo unarmed", 8'h00, v)
      `CHK("busy unarmed", 1'b0, nv_busy)
      core.wr(`NVC_ADDR_IND, 8'h01);
      core.idle;
      core.rd(`NVC_ADDR_IND, v);
      `CHK("rgo unarmed", 8'h00, v)
      // Write: arm then go in consecutive cycles
      core.wr(`NVC_ADDR_NVADDR, 8'h12);
      core.wr(`NVC_ADDR_NVDATA, 8'h5a);
      core.wr(`NVC_ADDR_IRQ, 8'h00);
      core.wr(`NVC_ADDR_IND, 8'h08);
      core.wr(`NVC_ADDR_IND, 8'h0c);
      core.wr(`NVC_ADDR_IRQ, 8'h10);
      core.idle;
      core.rd(`NVC_ADDR_IND, v);
      `CHK("write running", 8'h0c, v)
      poll(2);
      core.rd(`NVC_ADDR_IND, v);
      `CHK("write done", 8'h08, v)
      core.rd(`NVC_ADDR_IRQ, v);
      `CHK("write flags", 8'h1a, v)
      // Read back after clobbering the data register
      core.wr(`NVC_ADDR_NVDATA, 8'h00);
      core.wr(`NVC_ADDR_NVADDR, 8'h12);
      core.wr(`NVC_ADDR_IND, 8'h02);
      core.wr(`NVC_ADDR_IND, 8'h03);
      core.idle;
      poll(0);
      core.rd(`NVC_ADDR_NVDATA, v);
      `CHK("read data", 8'h5a, v)
      // Interrupt request, stack block and service
      core.wr(`NVC_ADDR_IRQ, 8'h1f);
      core.idle;
      `CHK("vector req", 1'b1, vector_req)
      core.stack_full <= 1'b1;
      core.idle;
      `CHK("stack full", 1'b0, vector_req)
      core.stack_full <= 1'b0;
      core.idle;
      core.ack;
      core.rd(`NVC_ADDR_IRQ, v);
      `CHK("after service", 8'h07, v)
      close_out;
   end
endmodule
